// [shared/fdr_cfg.svh]
// Constants for the floppy drive select and rate register block.
`ifndef FDR_CFG_SVH
`define FDR_CFG_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define FDR_AW 12
`define FDR_DW 32
`define FDR_RW 8

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FDR_IDX_DRV 10'h3F2
`define FDR_IDX_TAPE 10'h3F3
`define FDR_IDX_RSEL 10'h3F4
`define FDR_IDX_DATA 10'h3F5
`define FDR_IDX_RCTL 10'h3F7
`define FDR_IDX_MODE 10'h3F8
`define FDR_IDX_DTYPE 10'h3F9
`define FDR_IDX_BOOT 10'h3FA
`define FDR_IDX_STAT 10'h3FB

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FDR_DRV_RST 8'h00
`define FDR_RSEL_RST 7'h02
`define FDR_RATE_RST 2'h2
`define FDR_MODE_RST 8'h00
`define FDR_CFG_RST 8'h00
`define FDR_TAPE_RST 2'h0
`define FDR_CABLE_IDLE 8'hFF
`define FDR_PC_STEPS_RST 3'h3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FDR_DRV_NRESET 2
`define FDR_RSEL_SWRST 7
`define FDR_RSEL_PDOWN 6
`define FDR_RSEL_PC_HI 4
`define FDR_RSEL_PC_LO 2
`define FDR_MODE_ENH 2
`define FDR_MODE_DRT_HI 5
`define FDR_MODE_DRT_LO 4
`define FDR_BOOT_INV1 3
`define FDR_BOOT_INV0 2

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define FDR_PC_OFF 3'h7
`define FDR_PC_DEFAULT 3'h0
`define FDR_PC_DEF_FAST 3'h1
`define FDR_PC_DEF_SLOW 3'h3
`define FDR_PC_NONE 3'h0
`define FDR_DRT_STD 2'h0
`define FDR_DRT_3MODE 2'h1
`define FDR_SEL_300 2'h1
`define FDR_RESP_OKAY 2'h0
`define FDR_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FDR_CLK_NS 40
`define FDR_SWRST_NS 100
`define FDR_SWRST_CYC ((`FDR_SWRST_NS + `FDR_CLK_NS - 1) / `FDR_CLK_NS)

`endif

// [shared/fdr_pkg.sv]
// Types shared by the floppy drive select and rate register block.
package fdr_pkg;

  // ----------------------------------------------------------------------
  // Drive cable outputs
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] drive_select_n;
    logic [3:0] motor_on_n;
  } fdr_cable_t;

  // ----------------------------------------------------------------------
  // Modes and rates
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FDR_DEC_INT_NORMAL = 2'b00,
    FDR_DEC_INT_SWAP = 2'b01,
    FDR_DEC_EXT_NORMAL = 2'b10,
    FDR_DEC_EXT_SWAP = 2'b11
  } fdr_dec_mode_t;

  typedef enum logic [1:0] {
    FDR_RATE_500K = 2'b00,
    FDR_RATE_300K = 2'b01,
    FDR_RATE_250K = 2'b10,
    FDR_RATE_1M = 2'b11
  } fdr_rate_t;

endpackage : fdr_pkg

// [rtl/fdr_sync.sv]
// Two-flop synchroniser for the rate pin inputs.
`timescale 1ns/1ps
module fdr_sync #(
  parameter int WIDTH = 2
) (
  // Clock
  input wire logic aclk,
  // Asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // No reset: the media bits must survive every reset.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_ff;
      logic stable_ff;
      always_ff @(posedge aclk) begin
        meta_ff <= async_in[g];
        stable_ff <= meta_ff;
      end
      assign sync_out[g] = stable_ff;
    end
  endgenerate

endmodule : fdr_sync

// [rtl/fdr_decode.sv]
// Drive select and motor decode for the four cable modes.
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module fdr_decode (
  // Decode controls
  input wire fdr_pkg::fdr_dec_mode_t mode,
  input wire logic [1:0] sel,
  input wire logic [3:0] mot,
  // Decoded cable levels
  output fdr_pkg::fdr_cable_t cable
);
  import fdr_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] swap01(input logic [1:0] c);
    swap01 = c[1] ? c : {1'b0, ~c[0]};
  endfunction : swap01

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  always_comb begin
    logic [1:0] l;
    l = 2'b00;
    cable = `FDR_CABLE_IDLE;
    unique case (mode)
      FDR_DEC_INT_NORMAL: begin
        for (int p = 0; p < 4; p++) begin
          cable.drive_select_n[p] = ~((sel == 2'(p)) && mot[p]);
          cable.motor_on_n[p] = ~mot[p];
        end
      end
      FDR_DEC_INT_SWAP: begin
        for (int p = 0; p < 4; p++) begin
          l = swap01(2'(p));
          cable.drive_select_n[p] = ~((sel == l) && mot[l]);
          cable.motor_on_n[p] = ~mot[l];
        end
      end
      FDR_DEC_EXT_NORMAL: begin
        cable.drive_select_n[1:0] = sel;
        cable.motor_on_n[0] = ~mot[sel];
      end
      FDR_DEC_EXT_SWAP: begin
        cable.drive_select_n[1:0] = swap01(sel);
        cable.motor_on_n[0] = ~mot[sel];
      end
    endcase
  end

endmodule : fdr_decode

// [rtl/fdr_top.sv]
// Floppy drive select, tape drive and data rate registers on AXI4-Lite.
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module fdr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`FDR_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [`FDR_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`FDR_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [`FDR_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive cable
  output fdr_pkg::fdr_cable_t cable,
  // Two-way rate pins
  input wire logic [1:0] rate_pin_in,
  output logic [1:0] rate_pin_out,
  output logic [1:0] rate_pin_oe_n,
  // Controller side
  output fdr_pkg::fdr_rate_t data_rate,
  output logic [2:0] write_field_a_steps,
  output logic ctrl_reset,
  output logic low_power
);
  import fdr_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [`FDR_AW-1:0] a,
                               input logic [9:0] idx);
    hit = (a[`FDR_AW-1:2] == idx);
  endfunction : hit

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic awready_ff;
  logic wready_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [`FDR_AW-1:0] aw_addr_ff;
  logic [`FDR_RW-1:0] w_data_ff;
  logic w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [`FDR_DW-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] drv_ff;
  logic [7:0] mode_ff;
  logic [7:0] dtype_ff;
  logic [7:0] boot_ff;
  logic [1:0] tape_ff;
  logic [6:0] rsel_ff;
  logic [1:0] rate_eff_ff;
  logic [1:0] swrst_cnt_ff;
  logic low_power_ff;
  logic ctrl_reset_ff;
  fdr_rate_t data_rate_ff;
  logic [2:0] write_field_a_ff;
  fdr_cable_t cable_ff;
  logic [1:0] pin_out_ff;
  logic [1:0] pin_oe_n_ff;

  // ----------------------------------------------------------------------
  // Decoded strobes
  // ----------------------------------------------------------------------
  logic [1:0] pin_sync;
  fdr_cable_t nxt_cable;
  logic wr_go;
  logic wr_en;
  logic wr_mapped;
  logic rd_go;
  logic rd_mapped;
  logic [`FDR_RW-1:0] nxt_rdata;
  logic [`FDR_RW-1:0] tape_view;
  logic [2:0] nxt_write_field_a;
  fdr_rate_t nxt_rate;
  logic enhanced;
  logic wake;
  logic swrst_req;

  assign enhanced = mode_ff[`FDR_MODE_ENH];
  assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_en = wr_go && w_strb_ff;
  assign rd_go = s_axi_arvalid && arready_ff;
  assign wr_mapped = hit(aw_addr_ff, `FDR_IDX_DRV) ||
                     hit(aw_addr_ff, `FDR_IDX_TAPE) ||
                     hit(aw_addr_ff, `FDR_IDX_RSEL) ||
                     hit(aw_addr_ff, `FDR_IDX_DATA) ||
                     hit(aw_addr_ff, `FDR_IDX_RCTL) ||
                     hit(aw_addr_ff, `FDR_IDX_MODE) ||
                     hit(aw_addr_ff, `FDR_IDX_DTYPE) ||
                     hit(aw_addr_ff, `FDR_IDX_BOOT) ||
                     hit(aw_addr_ff, `FDR_IDX_STAT);
  assign rd_mapped = hit(s_axi_araddr, `FDR_IDX_DRV) ||
                     hit(s_axi_araddr, `FDR_IDX_TAPE) ||
                     hit(s_axi_araddr, `FDR_IDX_RSEL) ||
                     hit(s_axi_araddr, `FDR_IDX_DATA) ||
                     hit(s_axi_araddr, `FDR_IDX_RCTL) ||
                     hit(s_axi_araddr, `FDR_IDX_MODE) ||
                     hit(s_axi_araddr, `FDR_IDX_DTYPE) ||
                     hit(s_axi_araddr, `FDR_IDX_BOOT) ||
                     hit(s_axi_araddr, `FDR_IDX_STAT);
  // Reads at the rate select index stand for status register reads.
  assign wake = (rd_go && (hit(s_axi_araddr, `FDR_IDX_RSEL) ||
                           hit(s_axi_araddr, `FDR_IDX_DATA))) ||
                (wr_go && hit(aw_addr_ff, `FDR_IDX_DATA));
  assign swrst_req = wr_en && hit(aw_addr_ff, `FDR_IDX_RSEL) &&
                     w_data_ff[`FDR_RSEL_SWRST];

  // ----------------------------------------------------------------------
  // Rate pin synchroniser and cable decode
  // ----------------------------------------------------------------------
  fdr_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .async_in(rate_pin_in),
    .sync_out(pin_sync)
  );

  fdr_decode u_decode (
    .mode(fdr_dec_mode_t'(mode_ff[1:0])),
    .sel(drv_ff[1:0]),
    .mot(drv_ff[7:4]),
    .cable(nxt_cable)
  );

  // ----------------------------------------------------------------------
  // AXI write channels
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end else if (wr_go) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_bready && bvalid_ff) begin
        awready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b1;
      w_hold_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= 1'b0;
    end else begin
      if (s_axi_wvalid && wready_ff) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[`FDR_RW-1:0];
        w_strb_ff <= s_axi_wstrb[0];
        wready_ff <= 1'b0;
      end else if (wr_go) begin
        w_hold_ff <= 1'b0;
      end
      if (s_axi_bready && bvalid_ff) begin
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `FDR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? `FDR_RESP_OKAY : `FDR_RESP_SLVERR;
    end else if (s_axi_bready && bvalid_ff) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI read channels
  // ----------------------------------------------------------------------
  always_comb begin
    if (enhanced) begin
      tape_view = {pin_sync[1] ^ boot_ff[`FDR_BOOT_INV1],
                   pin_sync[0] ^ boot_ff[`FDR_BOOT_INV0],
                   dtype_ff[{drv_ff[1:0], 1'b1}],
                   dtype_ff[{drv_ff[1:0], 1'b0}],
                   boot_ff[1:0],
                   tape_ff};
    end else begin
      // A bus without tri-state cannot float, so the unused bits read 0.
      tape_view = {6'h00, tape_ff};
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (hit(s_axi_araddr, `FDR_IDX_DRV)) begin
      nxt_rdata = drv_ff;
    end else if (hit(s_axi_araddr, `FDR_IDX_TAPE)) begin
      nxt_rdata = tape_view;
    end else if (hit(s_axi_araddr, `FDR_IDX_MODE)) begin
      nxt_rdata = mode_ff;
    end else if (hit(s_axi_araddr, `FDR_IDX_DTYPE)) begin
      nxt_rdata = dtype_ff;
    end else if (hit(s_axi_araddr, `FDR_IDX_BOOT)) begin
      nxt_rdata = boot_ff;
    end else if (hit(s_axi_araddr, `FDR_IDX_STAT)) begin
      nxt_rdata = {low_power_ff, ctrl_reset_ff, rate_eff_ff,
                   write_field_a_ff, 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `FDR_RESP_OKAY;
    end else if (rd_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, nxt_rdata};
      rresp_ff <= rd_mapped ? `FDR_RESP_OKAY : `FDR_RESP_SLVERR;
    end else if (s_axi_rready && rvalid_ff) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_ff <= `FDR_DRV_RST;
      mode_ff <= `FDR_MODE_RST;
      dtype_ff <= `FDR_CFG_RST;
      boot_ff <= `FDR_CFG_RST;
    end else if (wr_en) begin
      if (hit(aw_addr_ff, `FDR_IDX_DRV)) begin
        drv_ff <= w_data_ff;
      end
      if (hit(aw_addr_ff, `FDR_IDX_MODE)) begin
        mode_ff <= w_data_ff;
      end
      if (hit(aw_addr_ff, `FDR_IDX_DTYPE)) begin
        dtype_ff <= w_data_ff;
      end
      if (hit(aw_addr_ff, `FDR_IDX_BOOT)) begin
        boot_ff <= w_data_ff;
      end
    end
  end

  // Only the hardware reset touches the tape bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tape_ff <= `FDR_TAPE_RST;
    end else if (wr_en && hit(aw_addr_ff, `FDR_IDX_TAPE)) begin
      tape_ff <= w_data_ff[1:0];
    end
  end

  // Bit 7 is never stored and bit 5 is held at zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsel_ff <= `FDR_RSEL_RST;
    end else if (wr_en && hit(aw_addr_ff, `FDR_IDX_RSEL)) begin
      rsel_ff <= {w_data_ff[`FDR_RSEL_PDOWN], 1'b0,
                  w_data_ff[`FDR_RSEL_PC_HI:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_eff_ff <= `FDR_RATE_RST;
    end else if (wr_en && (hit(aw_addr_ff, `FDR_IDX_RSEL) ||
                           hit(aw_addr_ff, `FDR_IDX_RCTL))) begin
      rate_eff_ff <= w_data_ff[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Soft reset and low power
  // ----------------------------------------------------------------------
  // The self-clearing reset is stretched to the controller's minimum width.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swrst_cnt_ff <= 2'h0;
    end else if (swrst_req) begin
      swrst_cnt_ff <= 2'(`FDR_SWRST_CYC);
    end else if (swrst_cnt_ff != 2'h0) begin
      swrst_cnt_ff <= swrst_cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reset_ff <= 1'b1;
    end else begin
      ctrl_reset_ff <= !drv_ff[`FDR_DRV_NRESET] || swrst_req ||
                       (swrst_cnt_ff != 2'h0);
    end
  end

  // Entering low power wins over a wake in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_power_ff <= 1'b0;
    end else if (wr_en && hit(aw_addr_ff, `FDR_IDX_RSEL) &&
                 w_data_ff[`FDR_RSEL_PDOWN] && !swrst_req) begin
      low_power_ff <= 1'b1;
    end else if (wake || ctrl_reset_ff) begin
      low_power_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Rate and precompensation decode
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rate = fdr_rate_t'(rate_eff_ff);
    if (mode_ff[`FDR_MODE_DRT_HI:`FDR_MODE_DRT_LO] == `FDR_DRT_3MODE &&
        rate_eff_ff == `FDR_SEL_300) begin
      nxt_rate = FDR_RATE_500K;
    end
  end

  always_comb begin
    nxt_write_field_a = rsel_ff[`FDR_RSEL_PC_HI:`FDR_RSEL_PC_LO];
    if (nxt_write_field_a == `FDR_PC_OFF) begin
      nxt_write_field_a = `FDR_PC_NONE;
    end else if (nxt_write_field_a == `FDR_PC_DEFAULT) begin
      nxt_write_field_a = (nxt_rate == FDR_RATE_1M) ? `FDR_PC_DEF_FAST
                                              : `FDR_PC_DEF_SLOW;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_rate_ff <= fdr_rate_t'(`FDR_RATE_RST);
      write_field_a_ff <= `FDR_PC_STEPS_RST;
    end else begin
      data_rate_ff <= nxt_rate;
      write_field_a_ff <= nxt_write_field_a;
    end
  end

  // ----------------------------------------------------------------------
  // Cable and pin outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cable_ff <= `FDR_CABLE_IDLE;
    end else begin
      cable_ff <= nxt_cable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff <= `FDR_RATE_RST;
      pin_oe_n_ff <= 2'h0;
    end else begin
      pin_out_ff <= rate_eff_ff;
      pin_oe_n_ff <= {2{enhanced}};
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign cable = cable_ff;
  assign rate_pin_out = pin_out_ff;
  assign rate_pin_oe_n = pin_oe_n_ff;
  assign data_rate = data_rate_ff;
  assign write_field_a_steps = write_field_a_ff;
  assign ctrl_reset = ctrl_reset_ff;
  assign low_power = low_power_ff;

endmodule : fdr_top

// [tb/fdr_drives.sv]
// Drive cable model that answers on the released rate pins.
`timescale 1ns/1ps
module fdr_drives (
  // Rate pin drive from the block
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  // Media code of the inserted disk
  input wire logic [1:0] media,
  // Resolved wire level
  output logic [1:0] pin_wire
);
  // The drive puts media ID only on lines the block released.
  assign pin_wire = (pin_oe_n & media) | (~pin_oe_n & pin_out);
endmodule : fdr_drives

// [tb/fdr_top_props.sv]
// Port checker for the drive select and rate registers.
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module fdr_top_props (
  // Clock, reset and bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`FDR_DW-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Block outputs
  input wire fdr_pkg::fdr_cable_t cable,
  input wire logic [1:0] rate_pin_oe_n,
  input wire fdr_pkg::fdr_rate_t data_rate,
  input wire logic [2:0] write_field_a_steps,
  input wire logic low_power
);
  import fdr_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST: assert property ($rose(aresetn) |-> cable == 8'hFF
    && data_rate == FDR_RATE_250K && write_field_a_steps == 3'h3
    && rate_pin_oe_n == 2'b00 && !low_power) else $error("bad reset state");
  AST_PC: assert property (write_field_a_steps != 3'h7)
    else $error("write_field_a step count out of range");
  AST_RZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("read data upper bits set");
  AST_WBUSY: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while answer pending");
  AST_BONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_RONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_BCODE: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("bad write response code");
endmodule : fdr_top_props
bind fdr_top fdr_top_props chk_u (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cable,
  .rate_pin_oe_n, .data_rate, .write_field_a_steps, .low_power);

// [tb/fdr_top_tb.sv]
// Self-checking bench for the drive select and rate registers.
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module fdr_top_tb;
  import fdr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, v, d, e;
  logic [31:0] seed = 32'h0000_690B;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, rate_pin_in, rate_pin_out;
  logic [1:0] rate_pin_oe_n, media = 2'b00;
  logic s_axi_arready, s_axi_rvalid, ctrl_reset, low_power;
  logic [2:0] write_field_a_steps;
  fdr_cable_t cable;
  fdr_rate_t data_rate;
  int bad_count = 0, check_count = 0;
  fdr_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cable, .rate_pin_in, .rate_pin_out, .rate_pin_oe_n,
    .data_rate, .write_field_a_steps, .ctrl_reset, .low_power);
  fdr_drives drv_u (.pin_out(rate_pin_out), .pin_oe_n(rate_pin_oe_n),
    .media, .pin_wire(rate_pin_in));
  initial forever #20 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Swap modes exchange drives 0 and 1; external modes drive only select lines 0-1 and motor line 0.
  function automatic logic [7:0] dec(input logic [1:0] m, s,
    input logic [3:0] n);
    logic [1:0] p;
    p = (m[0] && !s[1]) ? {1'b0, ~s[0]} : s;
    if (m[1])
      return {2'b00, p, 3'b001, ~n[s]};
    return {~(4'(n[s]) << p), m[0] ? ~{n[3:2], n[0], n[1]} : ~n};
  endfunction : dec
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic summarize(input int x = 0);
    bad_count += x;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // One transfer; a hung slave ends the run instead of stalling it.
  task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] w);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_araddr <= {a, 2'b00};
    s_axi_wdata <= {24'h00_0000, w};
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while ((we ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 60);
    d = s_axi_rdata;
    r = we ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 60) summarize(1);
  endtask : bus
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `FDR_IDX_MODE, m[7:0]);
      for (int s = 0; s < 4; s++) begin
        v = rnd();
        bus(1'b1, `FDR_IDX_DRV, {v[7:4], 2'b01, s[1:0]});
        repeat (2) @(posedge aclk);
        e = {24'h00_0000, dec(m[1:0], s[1:0], v[7:4])};
        chk(cable & (m[1] ? 8'h33 : 8'hFF), e);
      end
    end
    bus(1'b1, `FDR_IDX_TAPE, v[15:8]);
    bus(1'b0, `FDR_IDX_TAPE, 8'h00);
    chk(d, {30'h0000_0000, v[9:8]});
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      bus(1'b1, `FDR_IDX_RSEL, {3'b000, i[2:0], ~i[1:0]});
      @(posedge aclk);
      chk(data_rate, 2'(~i[1:0]));
      chk(write_field_a_steps, i == 7 ? 3'h0 : i == 0 ? 3'h1 : i[2:0]);
      bus(1'b1, `FDR_IDX_RCTL, {6'h00, v[1:0]});
      @(posedge aclk);
      chk(data_rate, v[1:0]);
      chk(rate_pin_out, v[1:0]);
    end
    bus(1'b0, `FDR_IDX_RSEL, 8'h00);
    chk(d, 32'h0000_0000);
    bus(1'b1, `FDR_IDX_MODE, 8'h04);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      media <= v[3:2];
      bus(1'b1, `FDR_IDX_DTYPE, v[15:8]);
      bus(1'b1, `FDR_IDX_BOOT, v[23:16]);
      bus(1'b1, `FDR_IDX_TAPE, v[7:0]);
      bus(1'b1, `FDR_IDX_DRV, {6'h01, v[25:24]});
      bus(1'b0, `FDR_IDX_TAPE, 8'h00);
      e = {24'h00_0000, v[3] ^ v[19], v[2] ^ v[18],
        v[{2'b01, v[25:24], 1'b1}], v[{2'b01, v[25:24], 1'b0}], v[17:16],
        v[1:0]};
      chk(d, e);
    end
    chk(rate_pin_oe_n, 2'b11);
    bus(1'b1, `FDR_IDX_RSEL, 8'h81);
    @(posedge aclk);
    chk(ctrl_reset, 1'b1);
    repeat (6) @(posedge aclk);
    chk(ctrl_reset, 1'b0);
    chk(data_rate, FDR_RATE_300K);
    bus(1'b0, `FDR_IDX_TAPE, 8'h00);
    chk(d, e);
    bus(1'b1, `FDR_IDX_RSEL, 8'h42);
    @(posedge aclk);
    chk(low_power, 1'b1);
    bus(1'b0, `FDR_IDX_RSEL, 8'h00);
    @(posedge aclk);
    chk(low_power, 1'b0);
    bus(1'b1, `FDR_IDX_MODE, 8'h14);
    bus(1'b1, `FDR_IDX_RCTL, 8'h01);
    @(posedge aclk);
    chk(data_rate, FDR_RATE_500K);
    bus(1'b0, 10'h3FF, 8'h00);
    chk(r, `FDR_RESP_SLVERR);
    summarize();
  end
endmodule : fdr_top_tb
